//--- verilog/sirf_defs.vh
/*
  Constants of the source input, range and function command block:
  register offsets, status bits, opcodes, legal limits and range tables.
  Assumes inclusion by its bare name from every design file that needs it.
*/
`ifndef SIRF_DEFS_VH
`define SIRF_DEFS_VH

// Register byte offsets
`define SIRF_A_CMD 8'h00
`define SIRF_A_MANT 8'h04
`define SIRF_A_EXP 8'h08
`define SIRF_A_STATUS 8'h0C
`define SIRF_A_MASK 8'h10
`define SIRF_A_STATE 8'h14
`define SIRF_A_OUTV 8'h18
`define SIRF_A_OUTI 8'h1C
`define SIRF_A_DWELL 8'h20

// Status and mask bit positions
`define SIRF_ST_ERR 0
`define SIRF_ST_DONE 1
`define SIRF_ST_W 2

// Command opcodes
`define SIRF_OP_CURR 3'h0
`define SIRF_OP_VOLT 3'h1
`define SIRF_OP_DWELL 3'h2
`define SIRF_OP_LOC 3'h3
`define SIRF_OP_RANGE 3'h4
`define SIRF_OP_FUNC 3'h5

// Decimal exponent of each base unit: 10 uA, 1 mV, 10 ms, 1 location
`define SIRF_EXP_CURR 9'h1FB
`define SIRF_EXP_VOLT 9'h1FD
`define SIRF_EXP_DWELL 9'h1FE
`define SIRF_EXP_LOC 9'h000

// Legal limits in base units
`define SIRF_MIN_CURR 32'h0000000A
`define SIRF_MAX_CURR 32'h000F6950
`define SIRF_MIN_VOLT 32'h00000001
`define SIRF_MAX_VOLT 32'h00018A88
`define SIRF_MIN_DWELL 32'h00000002
`define SIRF_MAX_DWELL 32'h000186A0
`define SIRF_MIN_LOC 32'h00000001
`define SIRF_MAX_LOC 32'h00000065

// Range group limits (groups 0..2) and steps in base units
`define SIRF_VLIM0 32'h000003F2
`define SIRF_VLIM1 32'h00002774
`define SIRF_VLIM2 32'h00018A88
`define SIRF_ILIM0 32'h00002774
`define SIRF_ILIM1 32'h00018A88
`define SIRF_ILIM2 32'h000F6950
`define SIRF_STEP0 32'h00000001
`define SIRF_STEP1 32'h0000000A
`define SIRF_STEP2 32'h00000064
`define SIRF_STBY_COUNTS 32'h00000004

// Miscellaneous
`define SIRF_RANGE_AUTO 4'h0
`define SIRF_RANGE_LAST 4'h8
`define SIRF_RESP_OKAY 2'h0
`define SIRF_RESP_SLVERR 2'h2

`endif

//--- verilog/sirf_dscale.v
/*
  Decimal scaler: turns mantissa times ten to a signed power into a count
  of base units, one decade per clock. Fractions are truncated.
  Assumes start is only raised while busy is low.
*/
`timescale 1ns/1ps
`include "sirf_defs.vh"

module sirf_dscale #(
  parameter VW = 32,
  parameter EW = 9
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Request
  input wire start,
  input wire [VW-1:0] mant,
  input wire [EW-1:0] shift,
  // Result
  output reg busy,
  output reg done,
  output reg [VW-1:0] value,
  output reg ovf
);

reg [VW-1:0] acc_reg;
reg [EW-1:0] sh_reg;
wire [VW+3:0] prod;

assign prod = {acc_reg, 3'b000} + {3'b000, acc_reg, 1'b0};

always @(posedge clk or posedge rst) begin
  if (rst) begin
    acc_reg <= {VW{1'b0}};
    sh_reg <= {EW{1'b0}};
    busy <= 1'b0;
    done <= 1'b0;
    value <= {VW{1'b0}};
    ovf <= 1'b0;
  end else begin
    done <= 1'b0;
    if (start) begin
      acc_reg <= mant;
      sh_reg <= shift;
      busy <= 1'b1;
      ovf <= 1'b0;
    end else if (busy) begin
      if (sh_reg == {EW{1'b0}} || acc_reg == {VW{1'b0}}) begin
        busy <= 1'b0;
        done <= 1'b1;
        value <= acc_reg;
      end else if (sh_reg[EW-1]) begin
        // Fraction dropped one decade at a time
        acc_reg <= acc_reg / 10;
        sh_reg <= sh_reg + {{(EW-1){1'b0}}, 1'b1};
      end else if (prod[VW+3:VW] != 4'h0) begin
        ovf <= 1'b1;
        busy <= 1'b0;
        done <= 1'b1;
        value <= acc_reg;
      end else begin
        acc_reg <= prod[VW-1:0];
        sh_reg <= sh_reg - {{(EW-1){1'b0}}, 1'b1};
      end
    end
  end
end

endmodule

//--- verilog/sirf_axil.v
/*
  AXI4-Lite slave front end. Turns bus writes into a one-cycle write
  strobe and bus reads into a one-cycle read strobe with a one-cycle answer.
  Assumes the core decodes addresses combinationally.
*/
`timescale 1ns/1ps
`include "sirf_defs.vh"

module sirf_axil #(
  parameter AW = 8
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // AXI4-Lite
  input wire [AW-1:0] awaddr,
  input wire awvalid,
  output wire awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output wire wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  input wire [AW-1:0] araddr,
  input wire arvalid,
  output wire arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  // Core side
  output wire wr_en,
  output reg [AW-1:0] wr_addr,
  output reg [31:0] wr_data,
  output reg [3:0] wr_strb,
  input wire wr_err,
  output wire rd_en,
  input wire [31:0] rd_data,
  input wire rd_err
);

reg aw_hold;
reg w_hold;

assign awready = !aw_hold && !bvalid;
assign wready = !w_hold && !bvalid;
assign wr_en = aw_hold && w_hold && !bvalid;
assign arready = !rvalid;
assign rd_en = arvalid && !rvalid;

always @(posedge clk or posedge rst) begin
  if (rst) begin
    aw_hold <= 1'b0;
    w_hold <= 1'b0;
    wr_addr <= {AW{1'b0}};
    wr_data <= 32'h00000000;
    wr_strb <= 4'h0;
    bvalid <= 1'b0;
    bresp <= `SIRF_RESP_OKAY;
    rvalid <= 1'b0;
    rdata <= 32'h00000000;
    rresp <= `SIRF_RESP_OKAY;
  end else begin
    if (awvalid && awready) begin
      aw_hold <= 1'b1;
      wr_addr <= awaddr;
    end
    if (wvalid && wready) begin
      w_hold <= 1'b1;
      wr_data <= wdata;
      wr_strb <= wstrb;
    end
    if (wr_en) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      bvalid <= 1'b1;
      bresp <= wr_err ? `SIRF_RESP_SLVERR : `SIRF_RESP_OKAY;
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
    if (rd_en) begin
      rvalid <= 1'b1;
      rdata <= rd_data;
      rresp <= rd_err ? `SIRF_RESP_SLVERR : `SIRF_RESP_OKAY;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end
end

endmodule

//--- verilog/sirf_top.v
/*
  Source input, range and function command interpreter: validates and
  stores current, voltage and dwell values per memory location, keeps the
  output range and the operate/standby state, flags illegal options.
  Assumes a command parser writes commands over AXI4-Lite, and that the
  panel key and device clear arrive as one-cycle pulses synchronous to CLK.
*/
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "sirf_defs.vh"

module sirf_top #(
  parameter DW = 20,
  parameter LOCS = 101
) (
  // Clock and reset
  input wire CLK,
  input wire SYS_RST,
  // AXI4-Lite slave
  input wire [7:0] AWADDR,
  input wire AWVALID,
  output wire AWREADY,
  input wire [31:0] WDATA,
  input wire [3:0] WSTRB,
  input wire WVALID,
  output wire WREADY,
  output wire [1:0] BRESP,
  output wire BVALID,
  input wire BREADY,
  input wire [7:0] ARADDR,
  input wire ARVALID,
  output wire ARREADY,
  output wire [31:0] RDATA,
  output wire [1:0] RRESP,
  output wire RVALID,
  input wire RREADY,
  // Front panel and bus clear events
  input wire PANEL_KEY,
  input wire DEV_CLR,
  // Output setting
  output reg [31:0] OUT_VOLT,
  output reg [31:0] OUT_CURR,
  output reg [31:0] OUT_DWELL,
  output reg OPERATE,
  output reg ILLEGAL_OPTION_ERROR,
  output wire IRQ
);

localparam S_IDLE = 3'b001;
localparam S_NORM = 3'b010;
localparam S_EXEC = 3'b100;

wire wr_en;
wire [7:0] wr_addr;
wire [31:0] wr_data;
wire [3:0] wr_strb;
wire rd_en;
reg [31:0] rd_data;
reg rd_err;
reg wr_err;
wire ns_busy;
wire ns_done;
wire [31:0] ns_value;
wire ns_ovf;

reg [2:0] state_reg;
reg [2:0] op_reg;
reg [31:0] mant_reg;
reg [7:0] exp_reg;
reg [2:0] status_reg;
reg [2:0] mask_reg;
reg auto_reg;
reg [1:0] vg_reg;
reg [1:0] ig_reg;
reg [6:0] loc_reg;
reg operate_reg;
reg [DW-1:0] curr_mem [0:LOCS-1];
reg [DW-1:0] volt_mem [0:LOCS-1];
reg [DW-1:0] dwell_mem [0:LOCS-1];
integer k;

////////////////////////////////////////////////////////////////////////////////
// Bus front end and decimal scaler

sirf_axil #(.AW(8)) u_axil (
  .clk(CLK), .rst(SYS_RST),
  .awaddr(AWADDR), .awvalid(AWVALID), .awready(AWREADY),
  .wdata(WDATA), .wstrb(WSTRB), .wvalid(WVALID), .wready(WREADY),
  .bresp(BRESP), .bvalid(BVALID), .bready(BREADY),
  .araddr(ARADDR), .arvalid(ARVALID), .arready(ARREADY),
  .rdata(RDATA), .rresp(RRESP), .rvalid(RVALID), .rready(RREADY),
  .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .wr_strb(wr_strb),
  .wr_err(wr_err), .rd_en(rd_en), .rd_data(rd_data), .rd_err(rd_err)
);

reg [8:0] base_exp;
wire [8:0] shift;
wire cmd_wr;
wire start_norm;

always @* begin
  case (op_reg)
    `SIRF_OP_CURR: base_exp = `SIRF_EXP_CURR;
    `SIRF_OP_VOLT: base_exp = `SIRF_EXP_VOLT;
    `SIRF_OP_DWELL: base_exp = `SIRF_EXP_DWELL;
    default: base_exp = `SIRF_EXP_LOC;
  endcase
end

// Exponent applies to current, voltage, dwell and location; location is then truncated
assign shift = {exp_reg[7], exp_reg} - base_exp;
assign cmd_wr = wr_en && wr_addr == `SIRF_A_CMD && wr_strb[0] && state_reg == S_IDLE;
assign start_norm = state_reg == S_NORM && !ns_busy && !ns_done;

sirf_dscale #(.VW(32), .EW(9)) u_scale (
  .clk(CLK), .rst(SYS_RST), .start(start_norm), .mant(mant_reg), .shift(shift),
  .busy(ns_busy), .done(ns_done), .value(ns_value), .ovf(ns_ovf)
);

////////////////////////////////////////////////////////////////////////////////
// Range helpers

function [31:0] vlim;
  input [1:0] g;
  begin
    vlim = (g == 2'd0) ? `SIRF_VLIM0 : (g == 2'd1) ? `SIRF_VLIM1 : `SIRF_VLIM2;
  end
endfunction

function [31:0] ilim;
  input [1:0] g;
  begin
    ilim = (g == 2'd0) ? `SIRF_ILIM0 : (g == 2'd1) ? `SIRF_ILIM1 : `SIRF_ILIM2;
  end
endfunction

function [31:0] step;
  input [1:0] g;
  begin
    step = (g == 2'd0) ? `SIRF_STEP0 : (g == 2'd1) ? `SIRF_STEP1 : `SIRF_STEP2;
  end
endfunction

// Truncation to the step leaves zero for anything under one step
function [31:0] quant;
  input [31:0] v;
  input [1:0] g;
  begin
    quant = v - (v % step(g));
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Command execution

reg x_err;
reg x_st_i;
reg x_st_v;
reg x_st_w;
reg x_loc;
reg x_func;
reg [31:0] x_val;
reg [1:0] x_vg;
reg [1:0] x_ig;
reg x_auto;
reg [1:0] fit_v;
reg [1:0] fit_i;
reg [3:0] rc;

always @* begin
  x_err = 1'b0;
  x_st_i = 1'b0;
  x_st_v = 1'b0;
  x_st_w = 1'b0;
  x_loc = 1'b0;
  x_func = 1'b0;
  x_val = ns_value;
  x_vg = vg_reg;
  x_ig = ig_reg;
  x_auto = auto_reg;
  rc = mant_reg[3:0] - 4'h1;
  fit_v = (ns_value <= `SIRF_VLIM0) ? 2'd0 : (ns_value <= `SIRF_VLIM1) ? 2'd1 : 2'd2;
  fit_i = (ns_value <= `SIRF_ILIM0) ? 2'd0 : (ns_value <= `SIRF_ILIM1) ? 2'd1 : 2'd2;
  case (op_reg)
    `SIRF_OP_CURR: begin
      if (ns_ovf || ns_value < `SIRF_MIN_CURR || ns_value > `SIRF_MAX_CURR) begin
        x_err = 1'b1;
      end else if (auto_reg) begin
        x_ig = fit_i;
        x_err = vg_reg == 2'd2 && fit_i == 2'd2;
        x_st_i = !x_err;
        x_val = quant(ns_value, fit_i);
      end else begin
        x_err = ns_value > ilim(ig_reg);
        x_st_i = !x_err;
        x_val = quant(ns_value, ig_reg);
      end
    end
    `SIRF_OP_VOLT: begin
      if (ns_ovf || ns_value < `SIRF_MIN_VOLT || ns_value > `SIRF_MAX_VOLT) begin
        x_err = 1'b1;
      end else if (auto_reg) begin
        x_vg = fit_v;
        x_err = ig_reg == 2'd2 && fit_v == 2'd2;
        x_st_v = !x_err;
        x_val = quant(ns_value, fit_v);
      end else begin
        x_err = ns_value > vlim(vg_reg);
        x_st_v = !x_err;
        x_val = quant(ns_value, vg_reg);
      end
    end
    `SIRF_OP_DWELL: begin
      x_err = ns_ovf || ns_value < `SIRF_MIN_DWELL || ns_value > `SIRF_MAX_DWELL;
      x_st_w = !x_err;
    end
    `SIRF_OP_LOC: begin
      x_err = ns_ovf || ns_value < `SIRF_MIN_LOC || ns_value > `SIRF_MAX_LOC;
      x_loc = !x_err;
    end
    `SIRF_OP_RANGE: begin
      if (mant_reg == 32'h00000000) begin
        x_auto = 1'b1;
      end else if (mant_reg <= {28'h0000000, `SIRF_RANGE_LAST}) begin
        x_auto = 1'b0;
        x_vg = (rc >= 4'h6) ? 2'd2 : (rc >= 4'h3) ? 2'd1 : 2'd0;
        x_ig = (rc == 4'h0 || rc == 4'h3 || rc == 4'h6) ? 2'd0 :
               (rc == 4'h1 || rc == 4'h4 || rc == 4'h7) ? 2'd1 : 2'd2;
      end else begin
        x_err = 1'b1;
      end
    end
    `SIRF_OP_FUNC: begin
      x_err = mant_reg > 32'h00000001;
      x_func = !x_err;
    end
    default: x_err = 1'b1;
  endcase
  if (x_err) begin
    x_vg = vg_reg;
    x_ig = ig_reg;
    x_auto = auto_reg;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Control state and memory

wire exec = state_reg == S_EXEC;
wire st_rd = rd_en && ARADDR == `SIRF_A_STATUS;
wire [2:0] st_set = {1'b0, exec, exec && x_err};

always @(posedge CLK or posedge SYS_RST) begin
  if (SYS_RST) begin
    state_reg <= S_IDLE;
    op_reg <= 3'h0;
    mant_reg <= 32'h00000000;
    exp_reg <= 8'h00;
    status_reg <= 3'h0;
    mask_reg <= 3'h0;
    auto_reg <= 1'b1;
    vg_reg <= 2'd0;
    ig_reg <= 2'd0;
    loc_reg <= 7'h00;
    operate_reg <= 1'b0;
    ILLEGAL_OPTION_ERROR <= 1'b0;
    for (k = 0; k < LOCS; k = k + 1) begin
      curr_mem[k] <= {DW{1'b0}};
      volt_mem[k] <= {DW{1'b0}};
      dwell_mem[k] <= {DW{1'b0}};
    end
  end else begin
    case (state_reg)
      S_IDLE: if (cmd_wr) state_reg <= (wr_data[2:0] >= `SIRF_OP_RANGE) ? S_EXEC : S_NORM;
      S_NORM: if (ns_done) state_reg <= S_EXEC;
      S_EXEC: state_reg <= S_IDLE;
      default: state_reg <= S_IDLE;
    endcase
    if (cmd_wr) op_reg <= wr_data[2:0];
    if (wr_en && wr_addr == `SIRF_A_MANT && state_reg == S_IDLE) begin
      for (k = 0; k < 4; k = k + 1) begin
        if (wr_strb[k]) mant_reg[k*8 +: 8] <= wr_data[k*8 +: 8];
      end
    end
    if (wr_en && wr_addr == `SIRF_A_EXP && wr_strb[0] && state_reg == S_IDLE) exp_reg <= wr_data[7:0];
    if (wr_en && wr_addr == `SIRF_A_MASK && wr_strb[0]) mask_reg <= wr_data[2:0];
    // Set wins over clear-on-read
    status_reg <= (st_rd ? 3'h0 : status_reg) | st_set;
    if (exec) begin
      ILLEGAL_OPTION_ERROR <= x_err;
      vg_reg <= x_vg;
      ig_reg <= x_ig;
      auto_reg <= x_auto;
      if (x_st_i) curr_mem[loc_reg] <= x_val[DW-1:0];
      if (x_st_v) volt_mem[loc_reg] <= x_val[DW-1:0];
      if (x_st_w) dwell_mem[loc_reg] <= x_val[DW-1:0];
      if (x_loc) loc_reg <= x_val[6:0] - 7'h01;
    end
    if (DEV_CLR) auto_reg <= 1'b1;
    // Bus command and panel key drive the same state; bus wins a tie
    if (exec && x_func) begin
      operate_reg <= mant_reg[0];
    end else if (PANEL_KEY) begin
      operate_reg <= !operate_reg;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Output setting and interrupt

always @(posedge CLK or posedge SYS_RST) begin
  if (SYS_RST) begin
    OUT_VOLT <= 32'h00000000;
    OUT_CURR <= 32'h00000000;
    OUT_DWELL <= 32'h00000000;
    OPERATE <= 1'b0;
  end else begin
    OPERATE <= operate_reg;
    OUT_DWELL <= {{(32-DW){1'b0}}, dwell_mem[loc_reg]};
    if (operate_reg) begin
      OUT_VOLT <= {{(32-DW){1'b0}}, volt_mem[loc_reg]};
      OUT_CURR <= {{(32-DW){1'b0}}, curr_mem[loc_reg]};
    end else begin
      OUT_VOLT <= `SIRF_STBY_COUNTS * step(vg_reg);
      OUT_CURR <= `SIRF_STBY_COUNTS * step(ig_reg);
    end
  end
end

assign IRQ = |(status_reg & mask_reg);

////////////////////////////////////////////////////////////////////////////////
// Register decode

wire [3:0] code_now = auto_reg ? `SIRF_RANGE_AUTO :
                      {2'b00, vg_reg} * 4'h3 + {2'b00, ig_reg} + 4'h1;
wire [3:0] code_act = {2'b00, vg_reg} * 4'h3 + {2'b00, ig_reg} + 4'h1;

always @* begin
  rd_err = 1'b0;
  case (ARADDR)
    `SIRF_A_CMD: rd_data = {28'h0000000, state_reg != S_IDLE, op_reg};
    `SIRF_A_MANT: rd_data = mant_reg;
    `SIRF_A_EXP: rd_data = {24'h000000, exp_reg};
    `SIRF_A_STATUS: rd_data = {29'h00000000, status_reg};
    `SIRF_A_MASK: rd_data = {29'h00000000, mask_reg};
    `SIRF_A_STATE: rd_data = {15'h0000, operate_reg, auto_reg, code_act, code_now,
                              loc_reg + 7'h01};
    `SIRF_A_OUTV: rd_data = OUT_VOLT;
    `SIRF_A_OUTI: rd_data = OUT_CURR;
    `SIRF_A_DWELL: rd_data = OUT_DWELL;
    default: begin
      rd_data = 32'h00000000;
      rd_err = 1'b1;
    end
  endcase
end

always @* begin
  case (wr_addr)
    `SIRF_A_CMD, `SIRF_A_MANT, `SIRF_A_EXP, `SIRF_A_MASK: wr_err = 1'b0;
    `SIRF_A_STATUS, `SIRF_A_STATE, `SIRF_A_OUTV, `SIRF_A_OUTI, `SIRF_A_DWELL: wr_err = 1'b0;
    default: wr_err = 1'b1;
  endcase
end

endmodule

//--- tb/sirf_chk.sv
/* Checker for sirf_top: bus answers, output bounds, operate/standby.
   Assumes binding into sirf_top; sees its ports only. */
`timescale 1ns/1ps
`include "sirf_defs.vh"
module sirf_chk (
  // Clock and reset
  input wire CLK,
  input wire SYS_RST,
  // Bus
  input wire [7:0] AWADDR,
  input wire AWVALID,
  input wire AWREADY,
  input wire WVALID,
  input wire WREADY,
  input wire [1:0] BRESP,
  input wire BVALID,
  input wire BREADY,
  input wire [7:0] ARADDR,
  input wire ARVALID,
  input wire ARREADY,
  input wire [31:0] RDATA,
  input wire [1:0] RRESP,
  input wire RVALID,
  input wire RREADY,
  // Events and outputs
  input wire PANEL_KEY,
  input wire [31:0] OUT_VOLT,
  input wire [31:0] OUT_CURR,
  input wire [31:0] OUT_DWELL,
  input wire OPERATE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  property p_bhold;
    BVALID && !BREADY |=> BVALID && $stable(BRESP);
  endproperty
  a_bhold: assert property (p_bhold)
    else $error("write answer dropped");
  property p_rhold;
    RVALID && !RREADY |=> RVALID && $stable(RDATA);
  endproperty
  a_rhold: assert property (p_rhold)
    else $error("read answer dropped");
  property p_wans;
    AWVALID && AWREADY && WVALID && WREADY |->
      ##2 BVALID && BRESP == ($past(AWADDR, 2) > 8'h20 ? 2'h2 : 2'h0);
  endproperty
  a_wans: assert property (p_wans)
    else $error("write answer late or wrong");
  property p_rans;
    ARVALID && ARREADY |=> RVALID && RRESP == ($past(ARADDR) > 8'h20 ? 2'h2 : 2'h0);
  endproperty
  a_rans: assert property (p_rans)
    else $error("read answer late or wrong");
  property p_rzero;
    RVALID && RRESP == 2'h2 |-> RDATA == 32'h0;
  endproperty
  a_rzero: assert property (p_rzero)
    else $error("error read carries data");
  property p_arrdy;
    ARREADY != RVALID;
  endproperty
  a_arrdy: assert property (p_arrdy)
    else $error("read address ready wrong");
  property p_stby;
    !OPERATE [*3] |-> (OUT_VOLT == 32'h4 || OUT_VOLT == 32'h28 || OUT_VOLT == 32'h190)
      && (OUT_CURR == 32'h4 || OUT_CURR == 32'h28 || OUT_CURR == 32'h190);
  endproperty
  a_stby: assert property (p_stby)
    else $error("standby output not four steps");
  property p_lim;
    OUT_VOLT <= `SIRF_MAX_VOLT && OUT_CURR <= `SIRF_MAX_CURR && OUT_DWELL <= `SIRF_MAX_DWELL;
  endproperty
  a_lim: assert property (p_lim)
    else $error("output above legal limit");
  property p_keyon;
    PANEL_KEY && !OPERATE |-> ##[1:3] OPERATE;
  endproperty
  a_keyon: assert property (p_keyon)
    else $error("key did not enter operate");
  property p_keyoff;
    PANEL_KEY && OPERATE |-> ##[1:3] !OPERATE;
  endproperty
  a_keyoff: assert property (p_keyoff)
    else $error("key did not enter standby");
endmodule
bind sirf_top sirf_chk u_chk (
  .CLK, .SYS_RST, .AWADDR, .AWVALID, .AWREADY, .WVALID, .WREADY, .BRESP, .BVALID,
  .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY,
  .PANEL_KEY, .OUT_VOLT, .OUT_CURR, .OUT_DWELL, .OPERATE
);

//--- tb/sirf_ctl.sv
/* Controller model: AXI4-Lite master, one write or one read at a time.
   Assumes wr and rd are called right after a rising clock edge. */
`timescale 1ns/1ps
module sirf_ctl (
  // Clock
  input wire clk,
  // Write channels
  output reg [7:0] awaddr,
  output reg awvalid,
  input wire awready,
  output reg [31:0] wdata,
  output reg [3:0] wstrb,
  output reg wvalid,
  input wire wready,
  input wire [1:0] bresp,
  input wire bvalid,
  output reg bready,
  // Read channels
  output reg [7:0] araddr,
  output reg arvalid,
  input wire arready,
  input wire [31:0] rdata,
  input wire [1:0] rresp,
  input wire rvalid,
  output reg rready
);
  initial begin
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'hF;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
  end
  // Sampling at the falling edge sees what the next rising edge samples
  task wr(input [7:0] a, input [31:0] d, output [1:0] r);
    reg aw_hs;
    reg w_hs;
    reg fin;
    begin
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wvalid <= 1'b1;
      fin = 1'b0;
      while (!fin) begin
        @(negedge clk);
        aw_hs = awvalid && awready;
        w_hs = wvalid && wready;
        fin = bvalid && bready;
        r = bresp;
        @(posedge clk);
        bready <= bvalid && !fin;
        if (aw_hs) begin
          awvalid <= 1'b0;
          awaddr <= ~a;
        end
        if (w_hs) begin
          wvalid <= 1'b0;
          wdata <= ~d;
        end
      end
    end
  endtask
  task rd(input [7:0] a, output [31:0] d, output [1:0] r);
    reg ar_hs;
    reg fin;
    begin
      araddr <= a;
      arvalid <= 1'b1;
      fin = 1'b0;
      while (!fin) begin
        @(negedge clk);
        ar_hs = arvalid && arready;
        fin = rvalid && rready;
        d = rdata;
        r = rresp;
        @(posedge clk);
        rready <= rvalid && !fin;
        if (ar_hs) begin
          arvalid <= 1'b0;
          araddr <= ~a;
        end
      end
    end
  endtask
endmodule

//--- tb/test_source_input_range_function_parser.sv
/* Bench for sirf_top: commands go through the controller model, an
   integer model predicts each result. Assumes sirf_ctl and sirf_chk. */
`timescale 1ns/1ps
`include "sirf_defs.vh"
module test_source_input_range_function_parser;
  reg CLK = 1'b0;
  reg SYS_RST = 1'b1;
  reg PANEL_KEY = 1'b0;
  reg DEV_CLR = 1'b0;
  wire [7:0] AWADDR, ARADDR;
  wire [31:0] WDATA, RDATA, OUT_VOLT, OUT_CURR, OUT_DWELL;
  wire [3:0] WSTRB;
  wire [1:0] BRESP, RRESP;
  wire AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, ARVALID, ARREADY;
  wire RVALID, RREADY, OPERATE, ILLEGAL_OPTION_ERROR, IRQ;
  integer err_total = 0;
  integer check_count = 0;
  integer cyc = 0;
  integer m_v [1:101];
  integer m_i [1:101];
  integer m_d [1:101];
  integer loc, rc, vg, ig, op, mask, i, k;
  reg [31:0] rdv;
  reg [1:0] rsp;
  sirf_top DUT (
    .CLK, .SYS_RST, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY,
    .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID,
    .RREADY, .PANEL_KEY, .DEV_CLR, .OUT_VOLT, .OUT_CURR, .OUT_DWELL, .OPERATE,
    .ILLEGAL_OPTION_ERROR, .IRQ
  );
  sirf_ctl ctl (
    .clk(CLK), .awaddr(AWADDR), .awvalid(AWVALID), .awready(AWREADY), .wdata(WDATA),
    .wstrb(WSTRB), .wvalid(WVALID), .wready(WREADY), .bresp(BRESP), .bvalid(BVALID),
    .bready(BREADY), .araddr(ARADDR), .arvalid(ARVALID), .arready(ARREADY),
    .rdata(RDATA), .rresp(RRESP), .rvalid(RVALID), .rready(RREADY)
  );
  always #10 CLK = ~CLK;
  always @(posedge CLK) begin
    cyc = cyc + 1;
    if (cyc == 50000) begin
      err_total = err_total + 1;
      end_of_test;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task end_of_test;
    begin
      if (err_total == 0 && check_count > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task chk(input string n, input [31:0] e, input [31:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        $display("[ERR] %0s expected %0h seen %0h", n, e, g);
        err_total = err_total + 1;
      end
    end
  endtask
  function integer p10(input integer n);
    p10 = n == 0 ? 1 : n == 1 ? 10 : 100;
  endfunction
  task outs;
    begin
      chk("volt", op ? m_v[loc] : 4 * p10(vg), OUT_VOLT);
      chk("curr", op ? m_i[loc] : 4 * p10(ig), OUT_CURR);
      chk("dwell", m_d[loc], OUT_DWELL);
      chk("operate", op, OPERATE);
    end
  endtask
  task st;
    begin
      ctl.rd(`SIRF_A_STATE, rdv, rsp);
      chk("state", loc | rc << 7 | (vg * 3 + ig + 1) << 11 | (rc == 0) << 15 | op << 16,
        rdv);
    end
  endtask
  // Model first, then the same command on the bus
  task cmd(input integer opc, input integer mt, input integer ex);
    integer j, v, e, lim, g;
    begin
      v = mt;
      for (j = ex + (opc == 0 ? 5 : opc == 1 ? 3 : opc == 2 ? 2 : 0); j > 0; j--)
        v = v * 10;
      for (j = ex + (opc == 0 ? 5 : opc == 1 ? 3 : opc == 2 ? 2 : 0); j < 0; j++)
        v = v / 10;
      e = 0;
      case (opc)
        0, 1: begin
          lim = opc ? 101000 : 1010000;
          g = 0;
          if (v < (opc ? 1 : 10) || v > lim)
            e = 1;
          else if (rc != 0) begin
            g = opc ? vg : ig;
            if (v > lim / p10(2 - g))
              e = 1;
          end else begin
            while (v > lim / p10(2 - g))
              g++;
            if (g == 2 && (opc ? ig : vg) == 2)
              e = 1;
            else if (opc)
              vg = g;
            else
              ig = g;
          end
          v = v / p10(g) * p10(g);
          if (!e && opc)
            m_v[loc] = v;
          if (!e && !opc)
            m_i[loc] = v;
        end
        2: if (v < 2 || v > 100000) e = 1; else m_d[loc] = v;
        3: if (v < 1 || v > 101) e = 1; else loc = v;
        4: begin
          if (mt > 8)
            e = 1;
          else
            rc = mt;
          if (mt > 0 && mt < 9) begin
            vg = (mt - 1) / 3;
            ig = (mt - 1) % 3;
          end
        end
        5: if (mt > 1) e = 1; else op = mt;
        default: e = 1;
      endcase
      ctl.wr(`SIRF_A_MANT, mt, rsp);
      ctl.wr(`SIRF_A_EXP, ex, rsp);
      ctl.wr(`SIRF_A_CMD, opc, rsp);
      rdv = 32'h8;
      for (j = 0; j < 300 && rdv[3]; j++)
        ctl.rd(`SIRF_A_CMD, rdv, rsp);
      chk("busy", 0, rdv & 32'h8);
      @(negedge CLK);
      chk("irq", |(mask & (2 + e)), IRQ);
      chk("option error", e, ILLEGAL_OPTION_ERROR);
      outs;
      @(posedge CLK);
      ctl.rd(`SIRF_A_STATUS, rdv, rsp);
      chk("status", 2 + e, rdv);
      st;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    for (i = 1; i <= 101; i = i + 1) begin
      m_v[i] = 0;
      m_i[i] = 0;
      m_d[i] = 0;
    end
    loc = 1;
    rc = 0;
    vg = 0;
    ig = 0;
    op = 0;
    mask = 0;
    k = $urandom(32'hFE018167);
    repeat (8) @(posedge CLK);
    SYS_RST <= 1'b0;
    @(posedge CLK);
    @(negedge CLK);
    outs;
    @(posedge CLK);
    st;
    ctl.rd(`SIRF_A_MASK, rdv, rsp);
    chk("mask", 0, rdv);
    ctl.rd(8'h40, rdv, rsp);
    chk("rresp", 2, rsp);
    ctl.wr(8'h44, 32'h1, rsp);
    chk("bresp", 2, rsp);
    ctl.wr(`SIRF_A_MASK, 32'h1, rsp);
    mask = 1;
    cmd(3, 19, -1);
    cmd(3, 101, 0);
    cmd(3, 102, 0);
    cmd(3, 0, 0);
    cmd(3, 2, 0);
    cmd(2, 25, -2);
    cmd(2, 1000, 0);
    cmd(2, 1001, 0);
    cmd(2, 1, -2);
    cmd(5, 1, 0);
    repeat (6) cmd(1, 1 + $urandom % 1010, -1);
    repeat (6) cmd(0, 1 + $urandom % 1010, -3);
    cmd(5, 2, 0);
    for (i = 0; i < 2; i = i + 1) begin
      PANEL_KEY <= 1'b1;
      @(posedge CLK);
      PANEL_KEY <= 1'b0;
      op = 1 - op;
      repeat (3) @(posedge CLK);
      @(negedge CLK);
      outs;
      @(posedge CLK);
    end
    ctl.wr(`SIRF_A_MASK, 32'h3, rsp);
    mask = 3;
    for (i = 1; i <= 8; i = i + 1) begin
      cmd(4, i, 0);
      cmd(5, 0, 0);
      cmd(5, 1, 0);
      cmd(1, 101000 / p10(2 - vg), -3);
      cmd(1, 101000 / p10(2 - vg) + 1, -3);
      cmd(1, p10(vg) - 1 + (vg == 0), -3);
      cmd(0, 1010000 / p10(2 - ig), -5);
      cmd(0, 1010000 / p10(2 - ig) + 1, -5);
      cmd(0, 99, -5);
    end
    cmd(4, 9, 0);
    cmd(6, 0, 0);
    DEV_CLR <= 1'b1;
    @(posedge CLK);
    DEV_CLR <= 1'b0;
    rc = 0;
    @(posedge CLK);
    st;
    cmd(1, 5, 0);
    cmd(0, 15, -1);
    cmd(1, 100, 0);
    end_of_test;
  end
endmodule
